// [core/mhe_emulator.sv]
// What this block does
// - Each step writes one winding only
// - Mode ON steps, OFF loads decay
// - Direction switch sets count, ON up
// - Block switches drive A8-A10, ON low
// - Channel switch drives address bit zero in decay mode
// - Level switches feed bit pairs, ON zero
// - Strobe toggle in decay mode gives one write pulse unless one is running
// - Eight-bit counter, MSB is marker
// - Edge flag low at block end while step is low
`include "mhe_regs.svh"
`default_nettype none
module mhe_emulator
    import mhe_pkg::*;
#(
    parameter int CNT_W = 8
)
(
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic        step_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic [10:0]      table_addr_o,
    output logic             winding_sel_o,
    output logic             ctrl_addr0_o,
    output logic [7:0]       ctrl_data_o,
    output logic             ctrl_wr_n_o,
    output logic             cycle_marker_o,
    output logic             block_edge_n_o
);
    localparam int WR_CYC =
        (`MHE_WR_PULSE_NS * (`MHE_CLK_HZ / 1000000) + 999) / 1000;

    // ======================================================
    // Bus slave
    logic [4:0]  ctrl;
    logic [4:0]  decay;
    logic        ack;
    logic [31:0] rdat;
    logic [4:0]  next_ctrl;
    logic [4:0]  next_decay;
    logic        next_ack;
    logic [31:0] next_rdat;
    logic        req;
    logic        mode_step;

    mhe_cnt_t    cnt;
    logic        wsel;
    logic        step_lvl;
    logic        step_rise;

    assign req = wb_cyc_i & wb_stb_i & ~ack;
    assign mode_step = ctrl[`MHE_CTRL_MODE];

    always_comb
    begin
        next_ctrl  = ctrl;
        next_decay = decay;
        next_ack   = req;
        next_rdat  = 32'h0000_0000;
        if (req && wb_we_i && wb_sel_i[0])
        begin
            if (wb_adr_i == `MHE_OFF_CTRL)
                next_ctrl = wb_dat_i[4:0];
            else if (wb_adr_i == `MHE_OFF_DECAY)
                next_decay = wb_dat_i[4:0];
        end
        if (req && !wb_we_i)
        begin
            if (wb_adr_i == `MHE_OFF_CTRL)
                next_rdat = {27'h0, ctrl};
            else if (wb_adr_i == `MHE_OFF_DECAY)
                next_rdat = {27'h0, decay};
            else if (wb_adr_i == `MHE_OFF_STATUS)
                next_rdat = {29'h0, block_edge_n_o, wsel, step_lvl};
            else if (wb_adr_i == `MHE_OFF_ADDR)
                next_rdat = {21'h0, table_addr_o};
            else if (wb_adr_i == `MHE_OFF_LEVEL)
                next_rdat = {24'h0, cnt};
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            ctrl  <= `MHE_CTRL_RST;
            decay <= `MHE_DECAY_RST;
            ack   <= 1'b0;
            rdat  <= 32'h0000_0000;
        end
        else
        begin
            ctrl  <= next_ctrl;
            decay <= next_decay;
            ack   <= next_ack;
            rdat  <= next_rdat;
        end
    end

    assign wb_ack_o = ack;
    assign wb_dat_o = rdat;

    // ======================================================
    // Step input from pin
    mhe_sync u_step
    (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .async_i (step_i),
        .level_o (step_lvl),
        .rise_o  (step_rise)
    );

    // ======================================================
    // Stepping: winding alternates, counter moves per microstep
    mhe_cnt_t next_cnt;
    logic     next_wsel;

    always_comb
    begin
        next_cnt  = cnt;
        next_wsel = wsel;
        if (mode_step && step_rise)
        begin
            next_wsel = ~wsel;
            if (wsel)
            begin
                if (ctrl[`MHE_CTRL_DIR])
                    next_cnt = cnt + 8'h01;
                else
                    next_cnt = cnt - 8'h01;
            end
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            cnt  <= 8'h00;
            wsel <= 1'b0;
        end
        else
        begin
            cnt  <= next_cnt;
            wsel <= next_wsel;
        end
    end

    // Switch ON means line low, hence inversion
    assign table_addr_o = {~ctrl[`MHE_CTRL_BLK_HI:`MHE_CTRL_BLK_LO],
                           cnt};
    assign winding_sel_o = wsel;
    assign cycle_marker_o = cnt[CNT_W-1];
    // Block end seen only while step is low
    assign block_edge_n_o = ~(~step_lvl &&
        ((ctrl[`MHE_CTRL_DIR] && cnt == 8'h00) ||
         (!ctrl[`MHE_CTRL_DIR] && cnt == 8'hFF)));

    // ======================================================
    // Decay write strobe, one pulse per toggle in decay mode while no pulse runs
    mhe_wr_e          wst;
    mhe_wr_e          next_wst;
    logic [3:0]       wcnt;
    logic [3:0]       next_wcnt;
    logic             strobe_prev;
    logic             strobe;

    assign strobe = decay[`MHE_DEC_WR];

    always_comb
    begin
        next_wst  = wst;
        next_wcnt = wcnt;
        case (wst)
            MHE_IDLE:
                if (!mode_step && strobe != strobe_prev)
                begin
                    next_wst  = MHE_PULSE;
                    next_wcnt = 4'(WR_CYC - 1);
                end
            MHE_PULSE:
                if (wcnt == 4'h0)
                    next_wst = MHE_IDLE;
                else
                    next_wcnt = wcnt - 4'h1;
            default:
                next_wst = MHE_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            wst         <= MHE_IDLE;
            wcnt        <= 4'h0;
            strobe_prev <= 1'b0;
        end
        else
        begin
            wst         <= next_wst;
            wcnt        <= next_wcnt;
            strobe_prev <= strobe;
        end
    end

    // Level ON gives zero in both bits of its pair
    logic [7:0] decay_word;
    assign decay_word = {2'b00,
                         {2{~decay[`MHE_DEC_LC]}},
                         {2{~decay[`MHE_DEC_LB]}},
                         {2{~decay[`MHE_DEC_LA]}}};

    // Stepping drives winding select as address bit zero
    assign ctrl_addr0_o = mode_step ? wsel
                                    : ~decay[`MHE_DEC_CHAN];
    assign ctrl_data_o  = mode_step ? 8'h00 : decay_word;
    assign ctrl_wr_n_o  = mode_step ? ~step_lvl
                                    : ~(wst == MHE_PULSE);

    // ======================================================
    // Checks
    AST_ONE_WINDING: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        mode_step && step_rise |=> wsel != $past(wsel))
        else $error("winding not alternated");
    AST_DECAY_FROZEN: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        !mode_step && !$past(mode_step) |=> $stable(cnt))
        else $error("counter moved in decay mode");
    AST_DIR_UP: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        mode_step && step_rise && wsel && ctrl[`MHE_CTRL_DIR]
        |=> cnt == $past(cnt) + 8'h01)
        else $error("count up wrong");
    AST_BLOCK_LOW: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        ctrl[`MHE_CTRL_BLK_LO] |-> !table_addr_o[8])
        else $error("block line not low");
    AST_CHAN: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        !mode_step |-> ctrl_addr0_o == ~decay[`MHE_DEC_CHAN])
        else $error("channel bit wrong");
    AST_LEVEL: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        !mode_step && decay[`MHE_DEC_LA] |-> ctrl_data_o[1:0] == 2'b00)
        else $error("level pair wrong");
    AST_PULSE: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        $fell(ctrl_wr_n_o) && !mode_step |-> ##[1:4] ctrl_wr_n_o)
        else $error("write pulse too long");
    AST_MARKER: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        cycle_marker_o == table_addr_o[7])
        else $error("marker not counter msb");
    AST_EDGE: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        step_lvl |-> block_edge_n_o)
        else $error("edge flag low while step high");
endmodule : mhe_emulator
`default_nettype wire

// [core/mhe_sync.sv]
`include "mhe_regs.svh"
`default_nettype none
// ==========================================================
// Two-stage synchroniser with rise detect
module mhe_sync
(
    input  wire logic mclk_i,
    input  wire logic rst_n_i,
    input  wire logic async_i,
    output logic      level_o,
    output logic      rise_o
);
    logic meta;
    logic stable;
    logic prev;
    logic next_meta;
    logic next_stable;
    logic next_prev;

    always_comb
    begin
        next_meta   = async_i;
        next_stable = meta;
        next_prev   = stable;
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            meta   <= 1'b0;
            stable <= 1'b0;
            prev   <= 1'b0;
        end
        else
        begin
            meta   <= next_meta;
            stable <= next_stable;
            prev   <= next_prev;
        end
    end

    assign level_o = stable;
    assign rise_o  = stable & ~prev;
endmodule : mhe_sync
`default_nettype wire

// [inc/mhe_pkg.sv]
`default_nettype none
// ==========================================================
// Types
package mhe_pkg;
    typedef enum logic [1:0] {
        MHE_IDLE,
        MHE_PULSE,
        MHE_WAIT
    } mhe_wr_e;
    typedef logic [7:0] mhe_cnt_t;
endpackage : mhe_pkg
`default_nettype wire

// [inc/mhe_regs.svh]
`ifndef MHE_REGS_SVH
`define MHE_REGS_SVH
// ==========================================================
// Register offsets (byte addresses)
`define MHE_OFF_CTRL    8'h00
`define MHE_OFF_DECAY   8'h04
`define MHE_OFF_STATUS  8'h08
`define MHE_OFF_ADDR    8'h0C
`define MHE_OFF_LEVEL   8'h10
// ==========================================================
// Control field positions
`define MHE_CTRL_MODE   0
`define MHE_CTRL_DIR    1
`define MHE_CTRL_BLK_LO 2
`define MHE_CTRL_BLK_HI 4
// Decay field positions
`define MHE_DEC_CHAN    0
`define MHE_DEC_LA      1
`define MHE_DEC_LB      2
`define MHE_DEC_LC      3
`define MHE_DEC_WR      4
// ==========================================================
// Reset values: every switch ON except the write strobe
`define MHE_CTRL_RST    5'h1F
`define MHE_DECAY_RST   5'h0F
// ==========================================================
// Timing
`define MHE_CLK_HZ      10000000
`define MHE_WR_PULSE_NS 200
`endif

// [tb/mhe_ctrl_model.sv]
`default_nettype none
// ==========================================================
// Controller write port: latches on the rising end of write
module mhe_ctrl_model
(
    input  wire logic       wr_n_i,
    input  wire logic       addr0_i,
    input  wire logic [7:0] data_i,
    output int              wr_count_o,
    output logic            addr0_o,
    output logic [7:0]      data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int count = 0;
    // Count may bump once at power-up; users compare deltas only
    always @(posedge wr_n_i)
    begin
        count   <= count + 1;
        addr0_o <= addr0_i;
        data_o  <= data_i;
    end
    assign wr_count_o = count;
endmodule : mhe_ctrl_model
`default_nettype wire

// [tb/test_microstep_host_emulator.sv]
`default_nettype none
module test_microstep_host_emulator;
    timeunit 1ns;
    timeprecision 1ns;
    // ======================================================
    // Signals
    logic        mclk_i = 0, rst_n_i = 0, step = 0;
    logic        cyc = 0, stb = 0, we = 0;
    logic [7:0]  adr = 8'h00, cdat, pdat;
    logic [31:0] wdat = 32'h0, q, rdat;
    logic [3:0]  sel = 4'h0;
    logic [10:0] taddr;
    logic        ack, wsel, a0, wr_n, mark, edge_n, pa0;
    int          failures = 0, checks = 0, n0, pcnt;
    // Decay rows: switch nibble, 3 spare, addr bit, data byte
    logic [15:0] rows [6] = '{16'h103F, 16'h213C, 16'h4133,
                              16'h810F, 16'hE100, 16'h013F};
    mhe_emulator uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .step_i(step), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
        .table_addr_o(taddr), .winding_sel_o(wsel),
        .ctrl_addr0_o(a0), .ctrl_data_o(cdat), .ctrl_wr_n_o(wr_n),
        .cycle_marker_o(mark), .block_edge_n_o(edge_n));
    mhe_ctrl_model peer (.wr_n_i(wr_n), .addr0_i(a0),
        .data_i(cdat), .wr_count_o(pcnt), .addr0_o(pa0),
        .data_o(pdat));
    // ======================================================
    // Tasks
    task automatic tally_and_finish();
        if (failures == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            failures++;
            $display("CHECK FAILED %s exp %0h got %0h", nm, e, g);
        end
    endtask : chk
    task automatic idle(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : idle
    // Classic cycle: hold until ack is sampled, then release
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge mclk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        sel  <= 4'hF;
        do @(posedge mclk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk("read", e, q);
    endtask : rd
    task automatic pulse(input int n);
        repeat (n)
        begin
            @(posedge mclk_i);
            step <= 1'b1;
            idle(6);
            step <= 1'b0;
            idle(6);
        end
    endtask : pulse
    // ======================================================
    // Sequence
    initial
    begin
        forever #50 mclk_i = ~mclk_i;
    end
    initial
    begin
        #2000000;
        failures++;
        tally_and_finish();
    end
    initial
    begin
        idle(6);
        rst_n_i <= 1'b1;
        rd(8'h00, 32'h1F);
        rd(8'h04, 32'h0F);
        rd(8'h14, 32'h0);
        chk("edge", 0, edge_n);
        n0 = pcnt;
        pulse(1);
        chk("wind", 1, wsel);
        chk("addr0", 1, a0);
        chk("writes", n0 + 1, pcnt);
        rd(8'h10, 32'h00);
        pulse(1);
        rd(8'h10, 32'h01);
        chk("taddr", 11'h001, taddr);
        wb(1'b1, 8'h00, 32'h07);
        chk("taddr", 11'h601, taddr);
        wb(1'b1, 8'h00, 32'h01);
        pulse(2);
        chk("taddr", 11'h700, taddr);
        chk("edge", 1, edge_n);
        pulse(2);
        chk("mark", 1, mark);
        chk("edge", 0, edge_n);
        chk("taddr", 11'h7FF, taddr);
        wb(1'b1, 8'h00, 32'h02);
        n0 = pcnt;
        pulse(2);
        rd(8'h10, 32'hFF);
        chk("writes", n0, pcnt);
        foreach (rows[i])
        begin
            wb(1'b1, 8'h04, {28'h0, rows[i][15:12]});
            chk("addr0", rows[i][8], a0);
            chk("data", rows[i][7:0], cdat);
        end
        n0 = pcnt;
        wb(1'b1, 8'h04, 32'h1E);
        idle(6);
        chk("writes", n0 + 1, pcnt);
        chk("pdata", 8'h00, pdat);
        chk("paddr", 1, pa0);
        wb(1'b1, 8'h04, 32'h0E);
        idle(6);
        chk("writes", n0 + 2, pcnt);
        wb(1'b1, 8'h00, 32'h1F);
        idle(6);
        n0 = pcnt;
        wb(1'b1, 8'h04, 32'h1E);
        idle(6);
        chk("writes", n0, pcnt);
        // Mid-run reset brings counter and switches home
        rst_n_i <= 1'b0;
        idle(2);
        rst_n_i <= 1'b1;
        rd(8'h00, 32'h1F);
        rd(8'h04, 32'h0F);
        rd(8'h10, 32'h00);
        chk("mark", 0, mark);
        chk("wind", 0, wsel);
        tally_and_finish();
    end
endmodule : test_microstep_host_emulator
`default_nettype wire
